// >>> shared/basic_timer_consts.vh
`ifndef BASIC_TIMER_CONSTS_VH
`define BASIC_TIMER_CONSTS_VH

`define TMR_ADDR_CTL_MAIN 12'h000
`define TMR_ADDR_CTL_TRIG 12'h004
`define TMR_ADDR_IRQ_DMA_EN 12'h00c
`define TMR_ADDR_FLAG 12'h010
`define TMR_ADDR_SW_EVENT 12'h014
`define TMR_ADDR_COUNT 12'h024
`define TMR_ADDR_PRESCALE 12'h028
`define TMR_ADDR_RELOAD 12'h02c
`define TMR_ADDR_REPEAT 12'h030

`define TMR_BIT_RUN 0
`define TMR_BIT_UPD_DIS 1
`define TMR_BIT_UPD_SRC 2
`define TMR_BIT_ONE_SHOT 3
`define TMR_BIT_RELOAD_SHADOW 7
`define TMR_MMODE_HI 6
`define TMR_MMODE_LO 4
`define TMR_BIT_IRQ_EN 0
`define TMR_BIT_DMA_EN 8
`define TMR_BIT_UPD_FLAG 0
`define TMR_BIT_UPD_GEN 0

`define TMR_MMODE_RESET 3'h0
`define TMR_MMODE_ENABLE 3'h1
`define TMR_MMODE_UPDATE 3'h2

`define TMR_RESET_VALUE 16'h0000

`endif

// >>> src/timer_prescaler.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// prescaler: one-cycle tick every (divide_value + 1) enabled cycles
// ----------------------------------------------------------------
module timer_prescaler #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // control
  input wire enable_in,
  input wire clear_in,
  input wire [WIDTH-1:0] divide_value_in,
  // tick
  output reg tick_out
);

  reg [WIDTH-1:0] count_q;

  always @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      count_q <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else if (enable_in) begin
      if (count_q >= divide_value_in) begin
        count_q <= {WIDTH{1'b0}};
        tick_out <= 1'b1;
      end else begin
        count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule // timer_prescaler
`default_nettype wire

// >>> src/basic_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "basic_timer_consts.vh"
module basic_timer (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // debug halt from the core, asynchronous
  input wire debug_halt_in,
  input wire debug_freeze_bit_in,
  // events
  output reg update_irq_out,
  output reg update_dma_req_out,
  output reg trigger_output_out,
  output reg [15:0] count_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] ctl_main_q;
  reg [2:0] master_mode_q;
  reg irq_en_q;
  reg dma_en_q;
  reg update_flag_q;
  reg [15:0] count_q;
  reg [15:0] prescale_pre_q;
  reg [15:0] prescale_act_q;
  reg [15:0] reload_pre_q;
  reg [15:0] reload_act_q;
  reg [7:0] repeat_pre_q;
  reg [7:0] repeat_act_q;
  reg upd_gen_q;
  reg halt_meta_q;
  reg halt_sync_q;
  reg freeze_meta_q;
  reg freeze_sync_q;
  reg [31:0] rdata_d;
  reg addr_ok_d;

  wire setup = psel_in && !penable_in;
  wire wr_setup = setup && pwrite_in;
  wire run = ctl_main_q[`TMR_BIT_RUN];
  wire upd_dis = ctl_main_q[`TMR_BIT_UPD_DIS];
  wire upd_src = ctl_main_q[`TMR_BIT_UPD_SRC];
  wire one_shot = ctl_main_q[`TMR_BIT_ONE_SHOT];
  wire shadow_on = ctl_main_q[`TMR_BIT_RELOAD_SHADOW];
  wire frozen = halt_sync_q && freeze_sync_q;
  wire [15:0] reload_use = shadow_on ? reload_act_q : reload_pre_q;
  wire tick;

  // ----------------------------------------------------------------
  // debug synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      halt_meta_q <= 1'b0;
      halt_sync_q <= 1'b0;
      freeze_meta_q <= 1'b0;
      freeze_sync_q <= 1'b0;
    end else begin
      halt_meta_q <= debug_halt_in;
      halt_sync_q <= halt_meta_q;
      freeze_meta_q <= debug_freeze_bit_in;
      freeze_sync_q <= freeze_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and events
  // ----------------------------------------------------------------
  timer_prescaler #(
    .WIDTH(16)
  ) u_prescaler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(run && !frozen),
    .clear_in(upd_gen_q),
    .divide_value_in(prescale_act_q),
    .tick_out(tick)
  );

  // the prescaler tick is registered one cycle behind its enable, so a
  // tick launched in the last running cycle must not move the counter
  wire step = tick && run && !frozen;
  wire overflow = step && (count_q >= reload_use);
  wire sw_update = upd_gen_q;
  wire update_ev = (overflow || sw_update) && !upd_dis;
  wire irq_ev = upd_src ? (overflow && !upd_dis) : update_ev;

  // ----------------------------------------------------------------
  // counter and shadows
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= `TMR_RESET_VALUE;
      prescale_act_q <= `TMR_RESET_VALUE;
      reload_act_q <= `TMR_RESET_VALUE;
      repeat_act_q <= 8'h00;
    end else begin
      if (sw_update) begin
        count_q <= 16'h0000;
      end else if (wr_setup && paddr_in == `TMR_ADDR_COUNT) begin
        count_q <= pwdata_in[15:0];
      end else if (overflow) begin
        count_q <= 16'h0000;
      end else if (step) begin
        count_q <= count_q + 16'h0001;
      end
      if (update_ev) begin
        prescale_act_q <= prescale_pre_q;
        reload_act_q <= reload_pre_q;
        repeat_act_q <= repeat_pre_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      ctl_main_q <= `TMR_RESET_VALUE;
      master_mode_q <= `TMR_MMODE_RESET;
      irq_en_q <= 1'b0;
      dma_en_q <= 1'b0;
      update_flag_q <= 1'b0;
      prescale_pre_q <= `TMR_RESET_VALUE;
      reload_pre_q <= `TMR_RESET_VALUE;
      repeat_pre_q <= 8'h00;
      upd_gen_q <= 1'b0;
    end else begin
      upd_gen_q <= 1'b0;
      if (wr_setup) begin
        case (paddr_in)
          `TMR_ADDR_CTL_MAIN: ctl_main_q <= {8'h00, pwdata_in[7], 3'h0,
            pwdata_in[3:0]};
          `TMR_ADDR_CTL_TRIG: master_mode_q <=
            pwdata_in[`TMR_MMODE_HI:`TMR_MMODE_LO];
          `TMR_ADDR_IRQ_DMA_EN: begin
            irq_en_q <= pwdata_in[`TMR_BIT_IRQ_EN];
            dma_en_q <= pwdata_in[`TMR_BIT_DMA_EN];
          end
          `TMR_ADDR_FLAG: begin
            if (!pwdata_in[`TMR_BIT_UPD_FLAG]) begin
              update_flag_q <= 1'b0;
            end
          end
          `TMR_ADDR_SW_EVENT: upd_gen_q <= pwdata_in[`TMR_BIT_UPD_GEN];
          `TMR_ADDR_PRESCALE: prescale_pre_q <= pwdata_in[15:0];
          `TMR_ADDR_RELOAD: reload_pre_q <= pwdata_in[15:0];
          `TMR_ADDR_REPEAT: repeat_pre_q <= pwdata_in[7:0];
          default: begin
          end
        endcase
      end
      if (irq_ev) begin
        update_flag_q <= 1'b1;
      end
      if (overflow && one_shot && !upd_dis) begin
        ctl_main_q[`TMR_BIT_RUN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // zero-extends a sixteen-bit register onto the read bus
  function [31:0] word16;
    input [15:0] value;
    begin
      word16 = {16'h0000, value};
    end
  endfunction

  always @* begin
    rdata_d = 32'h0000_0000;
    addr_ok_d = 1'b1;
    case (paddr_in)
      `TMR_ADDR_CTL_MAIN: rdata_d = word16(ctl_main_q);
      `TMR_ADDR_CTL_TRIG: rdata_d = {25'h0, master_mode_q, 4'h0};
      `TMR_ADDR_IRQ_DMA_EN: rdata_d = {23'h0, dma_en_q, 7'h0, irq_en_q};
      `TMR_ADDR_FLAG: rdata_d = {31'h0, update_flag_q};
      `TMR_ADDR_SW_EVENT: rdata_d = 32'h0000_0000;
      `TMR_ADDR_COUNT: rdata_d = word16(count_q);
      `TMR_ADDR_PRESCALE: rdata_d = word16(prescale_pre_q);
      `TMR_ADDR_RELOAD: rdata_d = word16(reload_pre_q);
      `TMR_ADDR_REPEAT: rdata_d = {24'h0, repeat_pre_q};
      default: addr_ok_d = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer and outputs
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      update_irq_out <= 1'b0;
      update_dma_req_out <= 1'b0;
      trigger_output_out <= 1'b0;
      count_out <= 16'h0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !addr_ok_d;
      prdata_out <= (setup && !pwrite_in) ? rdata_d : 32'h0000_0000;
      update_irq_out <= irq_en_q && (update_flag_q || irq_ev);
      update_dma_req_out <= dma_en_q && irq_ev;
      count_out <= count_q;
      case (master_mode_q)
        `TMR_MMODE_RESET: trigger_output_out <= sw_update;
        `TMR_MMODE_ENABLE: trigger_output_out <= run;
        `TMR_MMODE_UPDATE: trigger_output_out <= update_ev;
        default: trigger_output_out <= 1'b0;
      endcase
    end
  end

endmodule // basic_timer
`default_nettype wire

// >>> dv/basic_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------
// port checker
// ---------------
module basic_timer_checker (
  // clock, reset, bus
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // debug, events
  input wire logic debug_halt_in,
  input wire logic debug_freeze_bit_in,
  input wire logic update_irq_out,
  input wire logic update_dma_req_out,
  input wire logic [15:0] count_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error alone");
  property p_rdz; !pready_out |-> prdata_out == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("data idle");
  property p_cnt;
    $changed(count_out) && !$past(psel_in) |->
      count_out == $past(count_out) + 16'h1 || count_out == 16'h0;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count step");
  property p_frz;
    (debug_halt_in && debug_freeze_bit_in && !psel_in) [*6] |->
      $stable(count_out);
  endproperty
  a_frz: assert property (p_frz) else $error("count moved");
  property p_hold; update_irq_out && !psel_in |=> update_irq_out; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_dma; update_dma_req_out |=> !update_dma_req_out; endproperty
  a_dma: assert property (p_dma) else $error("dma held");
  property p_zero; update_dma_req_out |-> ##[0:2] count_out == 16'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("no restart");
  c_dma: cover property (update_dma_req_out);
  c_err: cover property (pslverr_out);
  c_irq: cover property ($rose(update_irq_out));
endmodule // basic_timer_checker
`default_nettype wire

// >>> dv/test_basic_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "basic_timer_consts.vh"
// ---------------
// bench top
// ---------------
module test_basic_timer;
  localparam logic [11:0] r_ctl = `TMR_ADDR_CTL_MAIN;
  localparam logic [11:0] r_trg = `TMR_ADDR_CTL_TRIG;
  localparam logic [11:0] r_en = `TMR_ADDR_IRQ_DMA_EN;
  localparam logic [11:0] r_flg = `TMR_ADDR_FLAG;
  localparam logic [11:0] r_sw = `TMR_ADDR_SW_EVENT;
  localparam logic [11:0] r_pre = `TMR_ADDR_PRESCALE;
  localparam logic [11:0] r_rld = `TMR_ADDR_RELOAD;
  localparam logic [11:0] r_cnt = `TMR_ADDR_COUNT;
  localparam logic [11:0] r_rep = `TMR_ADDR_REPEAT;
  logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, debug_halt_in = 0, debug_freeze_bit_in = 0, err;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, rd;
  wire logic [31:0] prdata_out;
  wire logic [15:0] count_out;
  wire logic pready_out, pslverr_out, update_irq_out;
  wire logic update_dma_req_out, trigger_output_out;
  int miscompares = 0, checks_done = 0, dma_n = 0, trg_n = 0, t;
  basic_timer dut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .debug_halt_in, .debug_freeze_bit_in, .update_irq_out,
    .update_dma_req_out, .trigger_output_out, .count_out);
  always #12.5 clk_in = ~clk_in;
  // event pulses are counted, so short pulses are never missed
  always @(posedge clk_in) begin
    dma_n <= dma_n + update_dma_req_out;
    trg_n <= trg_n + trigger_output_out;
  end
  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(bit b);
    if (b) begin
      miscompares++;
      stop_test;
    end
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i = 0;
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    // ready, data and error are all taken at the completing rising edge
    do @(posedge clk_in); while (pready_out !== 1'b1 && ++i < 50);
    tmo(i >= 50);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  task automatic chk(string n, logic [11:0] a, logic [31:0] e);
    apb(0, a, 0);
    cmp(n, e, rd);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wait_cnt(logic [15:0] v);
    int i = 0;
    do @(negedge clk_in); while (count_out !== v && ++i < 500);
    tmo(i >= 500);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    chk("ctl", r_ctl, 0);
    chk("en", r_en, 0);
    apb(0, 12'h100, 0);
    cmp("err", 1, err);
    apb(1, r_ctl, 32'hff86);
    chk("ctl", r_ctl, 32'h86);
    apb(1, r_trg, 32'hff2f);
    chk("trg", r_trg, 32'h20);
    apb(1, r_en, 32'hffff);
    chk("en", r_en, 32'h101);
    apb(1, r_ctl, 0);
    apb(1, r_pre, 2);
    apb(1, r_rld, 4);
    t = trg_n;
    apb(1, r_sw, 1);
    cyc(3);
    cmp("irq", 1, update_irq_out);
    cmp("dma", 1, dma_n);
    cmp("trg", t + 1, trg_n);
    chk("flag", r_flg, 1);
    apb(1, r_flg, 0);
    cyc(2);
    cmp("irq", 0, update_irq_out);
    apb(1, r_ctl, 1);
    apb(1, r_pre, 0);
    wait_cnt(2);
    cyc(3);
    cmp("cnt", 3, count_out);
    wait_cnt(0);
    wait_cnt(1);
    cyc(1);
    cmp("cnt", 2, count_out);
    cmp("irq", 1, update_irq_out);
    apb(1, r_ctl, 0);
    apb(1, r_sw, 1);
    apb(1, r_rld, 2);
    apb(1, r_ctl, 1);
    wait_cnt(2);
    cyc(1);
    cmp("cnt", 0, count_out);
    apb(1, r_ctl, 32'h09);
    wait_cnt(0);
    cyc(4);
    cmp("cnt", 0, count_out);
    chk("ctl", r_ctl, 32'h08);
    apb(1, r_trg, 32'h10);
    apb(1, r_ctl, 1);
    cyc(3);
    cmp("trg", 1, trigger_output_out);
    apb(1, r_trg, 0);
    apb(1, r_ctl, 32'h04);
    apb(1, r_flg, 0);
    t = trg_n;
    apb(1, r_sw, 1);
    cyc(3);
    cmp("trg", t + 1, trg_n);
    chk("flag", r_flg, 0);
    apb(1, r_ctl, 32'h02);
    apb(1, r_pre, 2);
    apb(1, r_sw, 1);
    apb(1, r_ctl, 32'h03);
    wait_cnt(1);
    cyc(1);
    cmp("cnt", 2, count_out);
    @(posedge clk_in);
    debug_halt_in <= 1;
    debug_freeze_bit_in <= 1;
    cyc(4);
    t = count_out;
    cyc(5);
    cmp("frz", t, count_out);
    apb(1, r_cnt, 32'h1234);
    chk("cnt", r_cnt, 32'h1234);
    cyc(1);
    cmp("cnt", 32'h1234, count_out);
    apb(1, r_rep, 32'h1ab);
    chk("rep", r_rep, 32'hab);
    // second reset in mid-run: registers and counter go back to zero
    @(posedge clk_in);
    rst_in <= 1;
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    cyc(1);
    cmp("cnt", 0, count_out);
    chk("ctl", r_ctl, 0);
    chk("en", r_en, 0);
    stop_test;
  end
endmodule // test_basic_timer
bind basic_timer basic_timer_checker u_chk (.clk_in, .rst_in, .psel_in,
  .penable_in, .prdata_out, .pready_out, .pslverr_out, .debug_halt_in,
  .debug_freeze_bit_in, .update_irq_out, .update_dma_req_out, .count_out);
`default_nettype wire
